// [adsc_pkg.sv]
// Summary of operation
// RULE_01 - Transfers are eight clocks, conversion 24
// RULE_02 - Command byte in, acquire, hold three later
// RULE_03 - Sixteen clocks of conversion follow command
// RULE_04 - Command starts with high bit seven
// RULE_05 - Decode channel, input mode, power mode fields
// RULE_06 - Single-ended codes map inputs zero to three
// RULE_07 - Differential codes map pairs and swaps
// RULE_08 - Power bits 00 sleep between conversions
// RULE_09 - Power bits 10 internal clock, 01 reserved
// RULE_10 - Power bits 11 always powered, external clock
// RULE_11 - Serial clock shifts data in all modes
// RULE_12 - Clock mode change takes one extra conversion
// RULE_13 - Host sets clock mode before power-down
// RULE_14 - Power-down keeps previous clock mode
// RULE_15 - Busy high one clock after command
// RULE_16 - Result bits MSB first on falling edges
// RULE_17 - Host gives at least 25 clocks
// RULE_18 - Next command may overlap the LSB
// RULE_19 - Zeros shifted after result bits; code holds the LSB on the line instead when the next command overlaps it
// RULE_20 - Outputs released while select high; busy stays driven while select is high in internal clock mode
// RULE_21 - Internal clock busy low at most 8 us
// RULE_22 - Result is 16-bit two's complement
// RULE_23 - Input sampled on rising serial clock
// RULE_24 - Select high discards partial command
package adsc_pkg;
  localparam int          CMD_BITS      = 8;
  localparam int          RES_BITS      = 16;
  localparam int          START_POS     = 7;
  localparam int          CHAN_HI       = 6;
  localparam int          CHAN_LO       = 4;
  localparam int          MODE_POS      = 2;
  localparam int          PWR_HI        = 1;
  localparam int          PWR_LO        = 0;
  localparam int          ACQ_BIT       = 5;
  localparam logic [1:0]  PWR_SLEEP     = 2'h0;
  localparam logic [1:0]  PWR_RSVD      = 2'h1;
  localparam logic [1:0]  PWR_INTCLK    = 2'h2;
  localparam logic [1:0]  PWR_EXTCLK    = 2'h3;
  localparam int          CLK_MHZ       = 100;
  localparam int          INT_CONV_US   = 8;
  localparam int          INT_CONV_CYC  = INT_CONV_US * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD  = 3'h1,
    ST_BUSY = 3'h2,
    ST_DATA = 3'h3,
    ST_ICNV = 3'h4,
    ST_TAIL = 3'h5
  } adsc_state_t;

  typedef struct packed {
    logic       pos_valid;
    logic [1:0] pos_input;
    logic       neg_is_common;
    logic [1:0] neg_input;
  } adsc_mux_t;

  typedef struct packed {
    logic       busy_o;
    logic       busy_oe_n;
    logic       sdo;
    logic       sdo_oe_n;
  } adsc_pins_t;
endpackage : adsc_pkg

// [adsc_ctrl.sv]
`timescale 1ns/1ps
module adsc_ctrl #(
  parameter int INT_CYC = adsc_pkg::INT_CONV_CYC
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  input  wire logic                  chip_sel_n,
  input  wire logic                  serial_shift_clock,
  input  wire logic                  serial_data_in,
  input  wire logic [15:0]           sample_code,
  output logic                       busy_out,
  output logic                       busy_oe_n,
  output logic                       serial_data_out,
  output logic                       sdo_oe_n,
  output logic                       acquire,
  output logic                       hold,
  output logic                       low_power,
  output logic                       int_clock_mode,
  output adsc_pkg::adsc_mux_t        mux_sel,
  output logic [15:0]                result_word
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [1:0]             cs_s;
    logic [1:0]             ck_s;
    logic [1:0]             di_s;
    logic                   ck_prev;
    logic                   cs_prev;
    adsc_pkg::adsc_state_t  st;
    logic [7:0]             sh;
    logic [4:0]             cnt;
    logic [15:0]            res;
    logic [15:0]            samp;
    logic                   intmode;
    logic                   cmode;
    logic [9:0]             icnt;
    logic                   res_ready;
    adsc_pkg::adsc_pins_t   pins;
    logic                   acq;
    logic                   hld;
    logic                   lp;
    adsc_pkg::adsc_mux_t    mux;
  } adsc_regs_t;

  adsc_regs_t r_q, r_d;

  // ==========================================================
  // Multiplexer decode
  function automatic adsc_pkg::adsc_mux_t mux_decode(input logic [2:0] ch, input logic sgl);
    adsc_pkg::adsc_mux_t m;
    m = '0;
    m.pos_valid     = (ch == 3'h1) || (ch == 3'h5) || (ch == 3'h2) || (ch == 3'h6);
    m.pos_input     = {ch[1], ch[2]};                             // RULE_06
    m.neg_is_common = sgl;
    m.neg_input     = sgl ? 2'h0 : {ch[1], ~ch[2]};               // RULE_07
    return m;
  endfunction : mux_decode

  logic ck_rise, ck_fall, cs_fall;
  assign ck_rise = r_q.ck_s[1] & ~r_q.ck_prev;                    // RULE_23
  assign ck_fall = ~r_q.ck_s[1] & r_q.ck_prev;
  assign cs_fall = ~r_q.cs_s[1] & r_q.cs_prev;

  // ==========================================================
  // Next state
  always_comb begin
    logic [7:0] nsh;
    nsh = {r_q.sh[6:0], r_q.di_s[1]};
    r_d = r_q;
    r_d.cs_s    = {r_q.cs_s[0], chip_sel_n};
    r_d.ck_s    = {r_q.ck_s[0], serial_shift_clock};
    r_d.di_s    = {r_q.di_s[0], serial_data_in};
    r_d.ck_prev = r_q.ck_s[1];
    r_d.cs_prev = r_q.cs_s[1];
    r_d.samp    = sample_code;
    if (cs_fall) begin
      r_d.pins.busy_o = 1'b0;                                     // RULE_20
    end
    // Internal conversion runs on its own timer, select may rise
    if (r_q.st == adsc_pkg::ST_ICNV) begin
      if (r_q.icnt == 10'(INT_CYC - 1)) begin
        r_d.pins.busy_o = 1'b1;                                   // RULE_21
        r_d.res_ready   = 1'b1;
        r_d.hld         = 1'b0;
        r_d.lp          = (r_q.sh[1:0] == adsc_pkg::PWR_SLEEP);   // RULE_08
        r_d.cnt         = '0;
        r_d.st          = adsc_pkg::ST_DATA;
      end else begin
        r_d.icnt = r_q.icnt + 10'h1;
      end
    end else if (r_q.cs_s[1]) begin
      r_d.st  = adsc_pkg::ST_IDLE;                                // RULE_24
      r_d.acq = 1'b0;
      r_d.hld = 1'b0;
      r_d.pins.sdo = 1'b0;
    end else begin
      unique case (r_q.st)
        adsc_pkg::ST_IDLE, adsc_pkg::ST_TAIL: begin
          if (ck_fall && r_q.st == adsc_pkg::ST_TAIL) begin
            r_d.pins.sdo = 1'b0;                                  // RULE_19
          end
          if (ck_rise && r_q.di_s[1]) begin                       // RULE_04
            r_d.sh  = nsh;
            r_d.cnt = 5'h1;
            r_d.st  = adsc_pkg::ST_CMD;
          end
        end
        adsc_pkg::ST_CMD: begin
          if (ck_rise) begin                                      // RULE_11
            r_d.sh  = nsh;
            r_d.cnt = r_q.cnt + 5'h1;
            if (r_q.cnt == 5'(adsc_pkg::ACQ_BIT - 1)) begin
              r_d.acq = 1'b1;                                     // RULE_02
              r_d.lp  = 1'b0;                                     // RULE_08
            end
            if (r_q.cnt == 5'(adsc_pkg::CMD_BITS - 1)) begin      // RULE_01
              r_d.acq = 1'b0;
              r_d.hld = 1'b1;                                     // RULE_02
              r_d.res = r_q.samp;                                 // RULE_22
              r_d.mux = mux_decode(nsh[adsc_pkg::CHAN_HI:adsc_pkg::CHAN_LO],
                                   nsh[adsc_pkg::MODE_POS]);      // RULE_05
              // Mode bits of this byte apply from the next conversion on
              if (nsh[1:0] == adsc_pkg::PWR_INTCLK) begin
                r_d.intmode = 1'b1;                               // RULE_09
              end else if (nsh[1:0] == adsc_pkg::PWR_EXTCLK) begin
                r_d.intmode = 1'b0;                               // RULE_10
              end
              r_d.cnt = '0;
              // Reported mode is the one this conversion really runs in
              r_d.cmode = r_q.intmode;                            // RULE_12
              if (r_q.intmode) begin                              // RULE_12 RULE_14
                r_d.icnt        = '0;
                r_d.pins.busy_o = 1'b0;
                r_d.res_ready   = 1'b0;
                r_d.st          = adsc_pkg::ST_ICNV;
              end else begin
                r_d.st = adsc_pkg::ST_BUSY;
              end
            end
          end
        end
        adsc_pkg::ST_BUSY: begin
          if (ck_fall) begin
            if (r_q.cnt == 5'h0) begin
              r_d.pins.busy_o = 1'b1;                             // RULE_15
              r_d.cnt = 5'h1;
            end else begin
              r_d.pins.busy_o = 1'b0;
              r_d.pins.sdo    = r_q.res[adsc_pkg::RES_BITS - 1];  // RULE_16
              r_d.res         = {r_q.res[14:0], 1'b0};
              r_d.cnt         = 5'h1;
              r_d.st          = adsc_pkg::ST_DATA;
            end
          end
        end
        adsc_pkg::ST_DATA: begin
          if (ck_fall) begin
            if (r_q.cnt == 5'(adsc_pkg::RES_BITS)) begin          // RULE_03
              r_d.pins.sdo = 1'b0;                                // RULE_19
              r_d.hld      = 1'b0;
              r_d.lp       = (r_q.sh[1:0] == adsc_pkg::PWR_SLEEP); // RULE_08
              r_d.st       = adsc_pkg::ST_TAIL;
            end else begin
              r_d.pins.sdo = r_q.res[adsc_pkg::RES_BITS - 1];     // RULE_16
              r_d.res      = {r_q.res[14:0], 1'b0};
              r_d.cnt      = r_q.cnt + 5'h1;
            end
          end
          if (ck_rise && r_q.di_s[1] && r_q.cnt == 5'(adsc_pkg::RES_BITS)) begin
            r_d.sh  = nsh;                                        // RULE_18
            r_d.cnt = 5'h1;
            r_d.hld = 1'b0;
            r_d.st  = adsc_pkg::ST_CMD;
          end
        end
        default: begin
          r_d.st = adsc_pkg::ST_IDLE;
        end
      endcase
    end
    // Busy stays driven in internal mode so the host can poll it
    r_d.pins.busy_oe_n = r_q.cs_s[1] && !r_q.cmode;               // RULE_20
    r_d.pins.sdo_oe_n  = r_q.cs_s[1];                             // RULE_20
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_q <= '{cs_s: 2'h3, cs_prev: 1'b1, st: adsc_pkg::ST_IDLE,
               pins: '{busy_o: 1'b0, busy_oe_n: 1'b1, sdo: 1'b0, sdo_oe_n: 1'b1},
               default: '0};
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign busy_out        = r_q.pins.busy_o;
  assign busy_oe_n       = r_q.pins.busy_oe_n;
  assign serial_data_out = r_q.pins.sdo;
  assign sdo_oe_n        = r_q.pins.sdo_oe_n;
  assign acquire         = r_q.acq;
  assign hold            = r_q.hld;
  assign low_power       = r_q.lp;
  assign int_clock_mode  = r_q.cmode;
  assign mux_sel         = r_q.mux;
  assign result_word     = r_q.res;
endmodule : adsc_ctrl

// [adsc_ctrl_asserts.sv]
`timescale 1ns/1ps
// ====================
// Port checks
module adsc_ctrl_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic chip_sel_n,
  input wire logic serial_shift_clock,
  input wire logic busy_out,
  input wire logic busy_oe_n,
  input wire logic serial_data_out,
  input wire logic sdo_oe_n,
  input wire logic acquire,
  input wire logic hold,
  input wire logic low_power,
  input wire logic int_clock_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Five cycles cover the select synchroniser and the output register
  sequence s_sel_high; chip_sel_n [*5]; endsequence
  sequence s_sel_low; !chip_sel_n [*6]; endsequence
  sequence s_busy_pulse; busy_out [*8] ##[4:10] !busy_out; endsequence
  property p_sdo_off; s_sel_high |-> sdo_oe_n; endproperty
  a_sdo_off: assert property (p_sdo_off) else $error("Data out driven while deselected");
  property p_busy_off; s_sel_high ##0 !int_clock_mode |-> busy_oe_n; endproperty
  a_busy_off: assert property (p_busy_off) else $error("Busy driven while deselected");
  property p_sdo_on; s_sel_low |-> !sdo_oe_n; endproperty
  a_sdo_on: assert property (p_sdo_on) else $error("Data out not driven while selected");
  property p_busy_low; $fell(chip_sel_n) && !int_clock_mode |-> ##[2:8] !busy_oe_n && !busy_out; endproperty
  a_busy_low: assert property (p_busy_low) else $error("Busy not low after select");
  property p_busy_width; $rose(busy_out) && !int_clock_mode |=> s_busy_pulse; endproperty
  a_busy_width: assert property (p_busy_width) else $error("Busy pulse not one serial period");
  property p_sdo_edge; $changed(serial_data_out) |-> !serial_shift_clock; endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("Data out moved on rising half");
  property p_acq_hold; $rose(acquire) |-> ##[40:58] $rose(hold); endproperty
  a_acq_hold: assert property (p_acq_hold) else $error("Hold not three clocks after acquire");
  property p_busy_in_hold; $rose(busy_out) && !int_clock_mode |-> hold && !acquire; endproperty
  a_busy_in_hold: assert property (p_busy_in_hold) else $error("Busy outside conversion");
  property p_sleep; low_power |-> !hold; endproperty
  a_sleep: assert property (p_sleep) else $error("Low power during conversion");
endmodule : adsc_ctrl_asserts

bind adsc_ctrl adsc_ctrl_asserts u_chk (.clk_sys(clk_sys), .reset(reset), .chip_sel_n(chip_sel_n),
  .serial_shift_clock(serial_shift_clock), .busy_out(busy_out), .busy_oe_n(busy_oe_n),
  .serial_data_out(serial_data_out), .sdo_oe_n(sdo_oe_n), .acquire(acquire), .hold(hold),
  .low_power(low_power), .int_clock_mode(int_clock_mode));

// [adsc_host_model.sv]
`timescale 1ns/1ps
// ====================
// Host serial port
module adsc_host_model (
  input  wire logic clk_sys,
  input  wire logic serial_data_out,
  input  wire logic sdo_oe_n,
  output logic      chip_sel_n,
  output logic      serial_shift_clock,
  output logic      serial_data_in
);
  initial begin
    chip_sel_n = 1'b1;
    serial_shift_clock = 1'b0;
    serial_data_in = 1'b0;
  end
  // Clock stands low between frames; a released data line reads inverted
  task automatic run(input logic [63:0] bits, input int n, output logic [63:0] rx);
    rx = '0;
    @(negedge clk_sys) chip_sel_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      serial_data_in = bits[63 - i];
      repeat (8) @(negedge clk_sys);
      serial_shift_clock = 1'b1;
      rx = {rx[62:0], serial_data_out ^ sdo_oe_n};
      repeat (8) @(negedge clk_sys);
      serial_shift_clock = 1'b0;
    end
    chip_sel_n = 1'b1;
    serial_data_in = ~serial_data_in;
  endtask : run
endmodule : adsc_host_model

// [adsc_ctrl_tb.sv]
`timescale 1ns/1ps
// ====================
// Bench top
module adsc_ctrl_tb;
  logic                clk_sys;
  logic                reset;
  logic                chip_sel_n;
  logic                serial_shift_clock;
  logic                serial_data_in;
  logic [15:0]         sample_code;
  logic                busy_out;
  logic                busy_oe_n;
  logic                serial_data_out;
  logic                sdo_oe_n;
  logic                acquire;
  logic                hold;
  logic                low_power;
  logic                int_clock_mode;
  adsc_pkg::adsc_mux_t mux_sel;
  logic [15:0]         result_word;
  logic [63:0]         rx;
  int                  num_errors;
  int                  samples_checked;

  // Short internal conversion keeps the run brief
  adsc_ctrl #(.INT_CYC(20)) u_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .chip_sel_n(chip_sel_n),
    .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in), .sample_code(sample_code),
    .busy_out(busy_out), .busy_oe_n(busy_oe_n), .serial_data_out(serial_data_out), .sdo_oe_n(sdo_oe_n),
    .acquire(acquire), .hold(hold), .low_power(low_power), .int_clock_mode(int_clock_mode),
    .mux_sel(mux_sel), .result_word(result_word));
  adsc_host_model u_host (.clk_sys(clk_sys), .serial_data_out(serial_data_out), .sdo_oe_n(sdo_oe_n),
    .chip_sel_n(chip_sel_n), .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in));

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conv(input logic [7:0] cmd, input int n);
    u_host.run({cmd, 56'h0}, n, rx);
    repeat (40) @(negedge clk_sys);
  endtask : conv
  task automatic t_reset;
    chk({busy_oe_n, sdo_oe_n, int_clock_mode}, 3'h6);
  endtask : t_reset
  task automatic t_ext;
    sample_code = 16'h1234;
    conv(8'h97, 32);
    chk(rx[22:0], {16'h1234, 7'h00});
  endtask : t_ext
  task automatic t_mux;
    logic [2:0]  sel [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
    logic [15:0] val [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
    for (int i = 0; i < 8; i++) begin
      sample_code = val[i % 4];
      conv({1'b1, sel[i % 4], 1'b0, i[2], 2'h3}, 25);
      chk(rx[15:0], val[i % 4]);
      chk({mux_sel.pos_valid, mux_sel.pos_input, mux_sel.neg_is_common}, {1'b1, i[1:0], i[2]});
      if (!i[2]) chk(mux_sel.neg_input, i[1:0] ^ 2'h1);
    end
  endtask : t_mux
  task automatic t_lead;
    sample_code = 16'hA5C3;
    u_host.run({4'hF, 60'h0}, 4, rx);
    repeat (40) @(negedge clk_sys);
    u_host.run({4'h0, 8'h97, 52'h0}, 29, rx);
    chk(rx[15:0], 16'hA5C3);
  endtask : t_lead
  task automatic t_ovl;
    sample_code = 16'h3C5A;
    u_host.run({8'h97, 16'h0, 8'h97, 32'h0}, 49, rx);
    repeat (40) @(negedge clk_sys);
    chk({rx[39:24], rx[15:0]}, {2{16'h3C5A}});
  endtask : t_ovl
  task automatic t_mode;
    logic [1:0] pw [6] = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h3, 2'h3};
    // Mode changes land one conversion late, so the first frame of each is not judged
    for (int i = 0; i < 6; i++) begin
      conv({6'h25, pw[i]}, 32);
      if (i != 0 && i != 4) chk(int_clock_mode, i < 4);
      if (i == 2) chk(low_power, 1'b1);
      if (i == 5) chk(low_power, 1'b0);
    end
  endtask : t_mode
  task automatic test_done;
    $display("Checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  initial begin
    num_errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    sample_code = 16'h0000;
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    t_reset();
    t_ext();
    t_mux();
    t_lead();
    t_ovl();
    t_mode();
    test_done();
  end
endmodule : adsc_ctrl_tb
